// >>> src/sbo_pkg.sv
// Shared constants and types for the serial bus output update link
package sbo_pkg;

    // ****************************************************************
    // Clock and frame timing
    // ****************************************************************
    localparam int CLK_HZ        = 10_000_000;
    localparam int RATE_SPLIT_HZ = 100_000;
    localparam int SYNC_SLOW     = 8;
    localparam int SYNC_FAST     = 16;
    localparam int DIV_DEF       = 50;
    localparam int FRAME_LEN_DEF = 16;
    localparam int N_CH_DEF      = 1;
    localparam int SYNC_DET_DEF  = 300;
    localparam int HOST_LAT      = 32;

    // ****************************************************************
    // Modes, addresses and widths
    // ****************************************************************
    localparam int MODE_PEER     = 1;
    localparam int MODE_MS       = 2;
    localparam int MUX_LO        = 1;
    localparam int MUX_N         = 4;
    localparam int DEB_SHORT     = 2;
    localparam int DEB_LONG      = 3;
    localparam int OUT_ADDR_DEF  = 5;
    localparam int IN_ADDR_DEF   = 6;
    localparam int PW            = 10;
    localparam int AW            = 8;
    localparam int CW            = 16;
    localparam int FIFO_DEPTH    = 16;
    localparam int FIFO_W        = AW + 1;
    localparam int LINK_SYNC_LAT = 2;

    localparam logic [PW-1:0] PULSE_MAX  = 10'h3FF;
    localparam logic [PW-1:0] PULSE_ONE  = 10'h001;
    localparam logic [PW-1:0] PULSE_LAG  = 10'(LINK_SYNC_LAT);
    localparam logic [PW-1:0] PULSE_SEEN = 10'(LINK_SYNC_LAT + 1);
    localparam logic [1:0]    DEB_CNT_MAX = 2'h3;

    typedef enum logic [2:0] {
        SRC_SYNC = 3'b001,
        SRC_HIGH = 3'b010,
        SRC_LOW  = 3'b100
    } sbo_src_state_t;

endpackage

// >>> src/sbo_if.sv
// Bus clock, low-true data line and fault-detect line between the two ends
`timescale 1ns/1ps
interface sbo_if;
    logic bus_clk;
    logic src_data_oe;
    logic dev_data_oe;
    logic src_bfd;
    logic bfd_short;
    logic data_line;
    logic bfd_line;

    // Resting pull-up from the clock source; any enable pulls the line low
    assign data_line = ~(src_data_oe | dev_data_oe);
    assign bfd_line  = src_bfd & ~bfd_short;

    modport source (output bus_clk, output src_data_oe, output src_bfd,
                    input data_line, input bfd_line);
    modport device (input bus_clk, input data_line, input bfd_line,
                    output dev_data_oe);
endinterface

// >>> src/sbo_device.sv
// I/O device end: frame capture, holding stage, debounce and output commit
`timescale 1ns/1ps
module sbo_device
    import sbo_pkg::*;
#(
    parameter int FRAME_LEN    = FRAME_LEN_DEF,
    parameter int MODE         = MODE_PEER,
    parameter int OUT_ADDR     = OUT_ADDR_DEF,
    parameter int IN_ADDR      = IN_ADDR_DEF,
    parameter int SYNC_DET_CYC = SYNC_DET_DEF
)(
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    sbo_if.device           bus,
    input  wire logic       in_bit_i,
    input  wire logic       cfg_deb_en_i,
    input  wire logic       cfg_deb_three_i,
    input  wire logic       cfg_mux_en_i,
    input  wire logic [3:0] cfg_chan_i,
    output logic            out_o,
    output logic            cfg_error_o,
    output logic            bfd_fault_o
);

    localparam logic [CW-1:0] DET_LAST = CW'(SYNC_DET_CYC - 1);
    localparam logic [PW-1:0] OUT_A    = PW'(OUT_ADDR);
    localparam logic [PW-1:0] IN_PULSE = (MODE == MODE_MS) ? PW'(2 * IN_ADDR - 1)
                                                           : PW'(IN_ADDR);
    localparam logic [PW-1:0] MUX_A_LO = PW'(MUX_LO);
    localparam logic [PW-1:0] MUX_A_HI = PW'(MUX_LO + MUX_N - 1);
    localparam logic [1:0]    LINK_RST_EDGES = 2'(LINK_SYNC_LAT + 1);

    // ****************************************************************
    // System domain: synchronisers
    // ****************************************************************
    logic bclk_s1;
    logic bclk_s2;
    logic bfd_s1;
    logic bfd_s2;
    logic bclk_s3;

    always_ff @(posedge clock_i)
    begin
        bclk_s1 <= bus.bus_clk;
        bclk_s2 <= bclk_s1;
        bclk_s3 <= bclk_s2;
        bfd_s1  <= bus.bfd_line;
        bfd_s2  <= bfd_s1;
    end

    // ****************************************************************
    // System domain: link reset stretch
    // ****************************************************************
    // The bus clock rests during reset, so the link side is held in reset
    // until it has had enough edges of its own to take the reset in
    logic [1:0] link_rise_cnt;
    logic       rst_hold;

    assign rst_hold = (link_rise_cnt != LINK_RST_EDGES);

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            link_rise_cnt <= 2'h0;
        else if (bclk_s2 && !bclk_s3 && rst_hold)
            link_rise_cnt <= link_rise_cnt + 2'h1;
    end

    // ****************************************************************
    // System domain: sync period recognition
    // ****************************************************************
    logic [CW-1:0] idle_cnt;
    logic          sync_found;
    logic          bfd_seen;
    logic          sync_tog;
    logic          bfd_ok;
    logic          snap_deb_en;
    logic          snap_deb_three;
    logic          snap_mux_en;
    logic [3:0]    snap_chan;
    logic          snap_reject;

    // Clock held low longer than any half period marks the sync
    assign sync_found = !bclk_s2 && (idle_cnt == DET_LAST);

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || bclk_s2)
            idle_cnt <= '0;
        else if (idle_cnt != CW'(SYNC_DET_CYC))
            idle_cnt <= idle_cnt + 1'b1;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || bclk_s2)
            bfd_seen <= 1'b0;
        else if (bfd_s2)
            bfd_seen <= 1'b1;
    end

    // Snapshot changes only with the toggle, so the link side may read it
    // directly once it has seen the toggle move
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            sync_tog       <= 1'b0;
            bfd_ok         <= 1'b0;
            bfd_fault_o    <= 1'b0;
            snap_deb_en    <= 1'b0;
            snap_deb_three <= 1'b0;
            snap_mux_en    <= 1'b0;
            snap_chan      <= 4'h0;
            snap_reject    <= 1'b0;
        end
        else if (sync_found)
        begin
            sync_tog       <= ~sync_tog;
            bfd_ok         <= bfd_seen | bfd_s2;
            bfd_fault_o    <= ~(bfd_seen | bfd_s2);
            snap_deb_en    <= cfg_deb_en_i;
            snap_deb_three <= cfg_deb_three_i;
            snap_mux_en    <= cfg_mux_en_i;
            snap_chan      <= cfg_chan_i;
            snap_reject    <= cfg_deb_en_i & cfg_mux_en_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            cfg_error_o <= 1'b0;
        else
            cfg_error_o <= cfg_deb_en_i & cfg_mux_en_i;
    end

    // ****************************************************************
    // Link domain: crossings in
    // ****************************************************************
    logic lrst_s1;
    logic lrst_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic inb_s1;
    logic inb_s2;
    logic sync_hit;

    always_ff @(posedge bus.bus_clk)
    begin
        lrst_s1 <= rst_hold;
        lrst_s2 <= lrst_s1;
        tog_s1  <= sync_tog;
        tog_s2  <= tog_s1;
        tog_s3  <= tog_s2;
        inb_s1  <= in_bit_i;
        inb_s2  <= inb_s1;
    end

    // Seen on the third clock edge after the sync
    assign sync_hit = tog_s2 ^ tog_s3;

    // ****************************************************************
    // Link domain: pulse count and delayed sample processing
    // ****************************************************************
    logic [PW-1:0] pulse;
    logic [PW-1:0] next_pulse;
    logic [PW-1:0] proc_pulse;
    logic [PW-1:0] proc_addr;
    logic          proc_out;
    logic [1:0]    hist;
    logic          proc_bit;

    always_comb
    begin
        if (sync_hit)
            next_pulse = PULSE_SEEN;
        else if (pulse == PULSE_MAX)
            next_pulse = PULSE_MAX;
        else
            next_pulse = pulse + PULSE_ONE;
    end

    // Samples are processed two edges late so that the first pulses of a
    // frame, taken before the sync is seen, still get their index
    assign proc_pulse = next_pulse - PULSE_LAG;
    assign proc_bit   = hist[1];
    assign proc_out   = (MODE == MODE_MS) ? ~proc_pulse[0] : 1'b1;
    assign proc_addr  = (MODE == MODE_MS) ? (proc_pulse >> 1) : proc_pulse;

    always_ff @(posedge bus.bus_clk)
    begin
        if (lrst_s2)
        begin
            pulse <= PULSE_MAX;
            hist  <= 2'h0;
        end
        else
        begin
            pulse <= next_pulse;
            hist  <= {hist[0], ~bus.data_line};
        end
    end

    // ****************************************************************
    // Link domain: channel, holding stage and debounce
    // ****************************************************************
    logic       l_mux_en;
    logic [3:0] l_chan;
    logic       l_reject;
    logic [3:0] chan_rx;
    logic       chan_match;
    logic       hold;
    logic       hold_new;
    logic [1:0] same_cnt;
    logic [1:0] deb_need;
    logic       out_l;

    assign chan_match = !l_mux_en || (chan_rx == l_chan);
    // Same snapshot as the commit enable, so length and enable agree
    assign deb_need   = snap_deb_three ? 2'(DEB_LONG) : 2'(DEB_SHORT);

    always_ff @(posedge bus.bus_clk)
    begin
        if (lrst_s2)
        begin
            l_mux_en    <= 1'b0;
            l_chan      <= 4'h0;
            l_reject    <= 1'b0;
        end
        else if (sync_hit)
        begin
            l_mux_en    <= snap_mux_en;
            l_chan      <= snap_chan;
            l_reject    <= snap_reject;
        end
    end

    always_ff @(posedge bus.bus_clk)
    begin
        if (lrst_s2)
            chan_rx <= 4'h0;
        else if (proc_out && proc_addr >= MUX_A_LO && proc_addr <= MUX_A_HI)
            chan_rx[2'(proc_addr - MUX_A_LO)] <= proc_bit;
    end

    always_ff @(posedge bus.bus_clk)
    begin
        if (lrst_s2)
        begin
            hold     <= 1'b0;
            hold_new <= 1'b0;
            same_cnt <= 2'h0;
        end
        else if (proc_out && proc_addr == OUT_A && chan_match)
        begin
            hold     <= proc_bit;
            hold_new <= 1'b1;
            if (proc_bit != hold)
                same_cnt <= 2'h1;
            else if (same_cnt != DEB_CNT_MAX)
                same_cnt <= same_cnt + 2'h1;
        end
        else if (sync_hit)
            hold_new <= 1'b0;
    end

    // Commit after the sync that follows the frame, only with a good check
    always_ff @(posedge bus.bus_clk)
    begin
        if (lrst_s2)
            out_l <= 1'b0;
        else if (sync_hit && hold_new && bfd_ok && !snap_reject)
        begin
            if (!snap_deb_en || same_cnt >= deb_need)
                out_l <= hold;
        end
    end

    // ****************************************************************
    // Link domain: input bit drive
    // ****************************************************************
    // Addresses whose pulse comes before the sync is seen cannot be driven
    logic drive_q;

    always_ff @(posedge bus.bus_clk)
    begin
        if (lrst_s2)
            drive_q <= 1'b0;
        else
            drive_q <= (next_pulse + PULSE_ONE == IN_PULSE)
                       && inb_s2 && chan_match && !l_reject;
    end

    // Masked until the link side has taken its reset, so no unknown reaches
    // the shared line
    assign bus.dev_data_oe = drive_q & ~rst_hold;

    // ****************************************************************
    // System domain: physical output
    // ****************************************************************
    logic out_s1;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || rst_hold)
        begin
            out_s1 <= 1'b0;
            out_o  <= 1'b0;
        end
        else
        begin
            out_s1 <= out_l;
            out_o  <= out_s1;
        end
    end

endmodule // sbo_device

// >>> src/sbo_source.sv
// Clock source end: bus clock, frame sequencing, fault pulse and output FIFO
`timescale 1ns/1ps
module sbo_fifo
    import sbo_pkg::*;
#(
    parameter int W     = FIFO_W,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic         clock_i,
    input  wire logic         sys_rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int PA = $clog2(DEPTH);

    logic [W-1:0] mem [0:DEPTH-1];
    logic [PA-1:0] wr_ptr;
    logic [PA-1:0] rd_ptr;
    logic [PA:0]   count;
    logic          push;
    logic          pop;

    assign in_ready_o  = (count != (PA+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i)
    begin
        if (push)
            mem[wr_ptr] <= in_data_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= push ? PA'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? PA'(rd_ptr + 1'b1) : rd_ptr;
            count  <= count + (PA+1)'(push) - (PA+1)'(pop);
        end
    end
endmodule // sbo_fifo

module sbo_source
    import sbo_pkg::*;
#(
    parameter int DIV       = DIV_DEF,
    parameter int FRAME_LEN = FRAME_LEN_DEF,
    parameter int MODE      = MODE_MS,
    parameter int N_CH      = N_CH_DEF,
    parameter int SYNC_OVR  = 0
)(
    input  wire logic          clock_i,
    input  wire logic          sys_rst_i,
    sbo_if.source              bus,
    input  wire logic          wr_valid_i,
    output logic               wr_ready_o,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic          wr_bit_i,
    output logic               in_valid_o,
    output logic [AW-1:0]      in_addr_o,
    output logic               in_bit_o,
    output logic [3:0]         channel_o,
    output logic               fault_o,
    input  wire logic          fault_clr_i
);
    // ****************************************************************
    // Derived timing
    // ****************************************************************
    localparam int RATE_HZ  = CLK_HZ / (2 * DIV);
    localparam int SYNC_LEN = (SYNC_OVR != 0) ? SYNC_OVR
                            : ((RATE_HZ > RATE_SPLIT_HZ) ? SYNC_FAST : SYNC_SLOW);
    localparam logic [CW-1:0] HALF_LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] SYNC_LAST = CW'(SYNC_LEN * 2 * DIV - 1);
    localparam logic [CW-1:0] PRE_DRIVE = CW'(SYNC_LEN * 2 * DIV - DIV - 1);
    localparam logic [CW-1:0] BFD_CYC   = CW'(2 * DIV);
    localparam logic [PW-1:0] LAST_P    = PW'(MODE * FRAME_LEN);
    localparam logic [3:0]    CH_LAST   = 4'(N_CH - 1);

    sbo_src_state_t state;
    logic [CW-1:0]  cnt;
    logic [PW-1:0]  pulse;
    logic [3:0]     chan;
    logic           tbl [0:(1<<AW)-1];
    logic           data_s1;
    logic           data_s2;
    logic           bfd_s1;
    logic           bfd_s2;
    logic           fifo_valid;
    logic [AW:0]    fifo_word;

    function automatic logic [PW-1:0] addr_of(input logic [PW-1:0] p);
        addr_of = (MODE == MODE_MS) ? ((p + PULSE_ONE) >> 1) : p;
    endfunction

    function automatic logic drive_of(input logic [PW-1:0] p);
        logic [PW-1:0] a;
        logic          is_mux;
        a        = addr_of(p);
        is_mux   = (a >= PW'(MUX_LO)) && (a <= PW'(MUX_LO + MUX_N - 1));
        drive_of = 1'b0;
        if (MODE != MODE_MS || !p[0])
        begin
            if (is_mux)
                drive_of = chan[2'(a - PW'(MUX_LO))];
            else if (MODE == MODE_MS)
                drive_of = tbl[AW'(a)];
        end
    endfunction

    // ****************************************************************
    // Output FIFO, drained into the table only during sync
    // ****************************************************************
    // In MODE_MS, host writes outside the mux addresses reach the bus at the next frame at the earliest, which
    // stands in for the host path delay; in MODE_PEER the table never drives the bus
    sbo_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i    (clock_i),
        .sys_rst_i  (sys_rst_i),
        .in_valid_i (wr_valid_i),
        .in_ready_o (wr_ready_o),
        .in_data_i  ({wr_addr_i, wr_bit_i}),
        .out_valid_o(fifo_valid),
        .out_ready_i(state == SRC_SYNC),
        .out_data_o (fifo_word)
    );

    always_ff @(posedge clock_i)
    begin
        if (fifo_valid && state == SRC_SYNC)
            tbl[fifo_word[AW:1]] <= fifo_word[0];
    end

    // ****************************************************************
    // Clock generation and frame sequence
    // ****************************************************************
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            state           <= SRC_SYNC;
            cnt             <= '0;
            pulse           <= '0;
            chan            <= 4'h0;
            bus.bus_clk     <= 1'b0;
            bus.src_data_oe <= 1'b0;
        end
        else
        begin
            case (state)
                SRC_SYNC:
                begin
                    if (cnt == PRE_DRIVE)
                        bus.src_data_oe <= drive_of(PULSE_ONE);
                    if (cnt == SYNC_LAST)
                    begin
                        cnt         <= '0;
                        pulse       <= PULSE_ONE;
                        bus.bus_clk <= 1'b1;
                        state       <= SRC_HIGH;
                    end
                    else
                        cnt <= cnt + 1'b1;
                end
                SRC_HIGH:
                begin
                    if (cnt == HALF_LAST)
                    begin
                        cnt             <= '0;
                        bus.bus_clk     <= 1'b0;
                        bus.src_data_oe <= (pulse == LAST_P) ? 1'b0
                                                             : drive_of(pulse + PULSE_ONE);
                        state           <= SRC_LOW;
                    end
                    else
                        cnt <= cnt + 1'b1;
                end
                SRC_LOW:
                begin
                    if (cnt == HALF_LAST)
                    begin
                        cnt <= '0;
                        if (pulse == LAST_P)
                        begin
                            chan  <= (chan == CH_LAST) ? 4'h0 : chan + 4'h1;
                            state <= SRC_SYNC;
                        end
                        else
                        begin
                            pulse       <= pulse + PULSE_ONE;
                            bus.bus_clk <= 1'b1;
                            state       <= SRC_HIGH;
                        end
                    end
                    else
                        cnt <= cnt + 1'b1;
                end
                default:
                    state <= SRC_SYNC;
            endcase
        end
    end

    // ****************************************************************
    // Fault-detect pulse and its supervision
    // ****************************************************************
    always_ff @(posedge clock_i)
    begin
        bfd_s1  <= bus.bfd_line;
        bfd_s2  <= bfd_s1;
        data_s1 <= bus.data_line;
        data_s2 <= data_s1;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            bus.src_bfd <= 1'b0;
        else
            bus.src_bfd <= (state == SRC_SYNC) && (cnt < BFD_CYC);
    end

    // Checked at the end of the pulse; a new fault beats a clear
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            fault_o <= 1'b0;
        else if (state == SRC_SYNC && cnt == BFD_CYC && !bfd_s2)
            fault_o <= 1'b1;
        else if (fault_clr_i)
            fault_o <= 1'b0;
    end

    // ****************************************************************
    // Input sampling just before each rising edge
    // ****************************************************************
    logic          smp_now;
    logic [PW-1:0] smp_pulse;

    assign smp_now   = (state == SRC_LOW && cnt == HALF_LAST && pulse != LAST_P)
                    || (state == SRC_SYNC && cnt == SYNC_LAST);
    assign smp_pulse = (state == SRC_SYNC) ? PULSE_ONE : pulse + PULSE_ONE;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            in_valid_o <= 1'b0;
            in_addr_o  <= '0;
            in_bit_o   <= 1'b0;
            channel_o  <= 4'h0;
        end
        else
        begin
            in_valid_o <= smp_now && (MODE != MODE_MS || smp_pulse[0]);
            in_addr_o  <= AW'(addr_of(smp_pulse));
            in_bit_o   <= ~data_s2;
            channel_o  <= chan;
        end
    end

endmodule // sbo_source

// >>> test/sbo_props.sv
// Link timing checks between clock source and device
`timescale 1ns/1ps
module sbo_props (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic bus_clk,
    input wire logic src_data_oe,
    input wire logic dev_data_oe,
    input wire logic src_bfd
);
    logic [8:0] low_cnt;
    always_ff @(posedge clock_i)
    begin
        low_cnt <= (sys_rst_i || bus_clk) ? 9'h000 : low_cnt + 9'h001;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    a_clk_high_half: assert property (
        $rose(bus_clk) |-> bus_clk[*8] ##1 !bus_clk) else $error("clock high phase");
    // Bus clock rate is above 100 kHz here, so sync is sixteen periods
    a_sync_length: assert property (
        $rose(bus_clk) && low_cnt > 9'h008 |-> low_cnt inside {[9'h0F0:9'h110]})
        else $error("sync length");
    a_bfd_in_sync: assert property (src_bfd |-> !bus_clk)
        else $error("fault pulse outside sync");
    a_bfd_pulse_width: assert property (
        $rose(src_bfd) |-> ##15 src_bfd ##1 !src_bfd) else $error("fault pulse width");
    a_dev_quiet_sync: assert property (src_bfd |-> !dev_data_oe)
        else $error("device drives in sync");
    a_dev_one_pulse: assert property (
        $rose(dev_data_oe) |-> dev_data_oe[*8] ##[8:10] !dev_data_oe)
        else $error("device drive length");
    a_src_falling_edge: assert property ($changed(src_data_oe) |-> !bus_clk)
        else $error("source data change");
    a_dev_rising_edge: assert property ($changed(dev_data_oe) |-> bus_clk)
        else $error("device data change");
    cover property ($rose(src_bfd));
    cover property ($rose(dev_data_oe));
    cover property (src_data_oe && bus_clk);
endmodule // sbo_props

// >>> test/serial_bus_output_update_tb.sv
// Bench joining clock source and device over the link
`timescale 1ns/1ps
module serial_bus_output_update_tb;
    import sbo_pkg::*;
    logic          clock_i   = 1'b0;
    logic          sys_rst_i = 1'b1;
    logic          wr_valid  = 1'b0;
    logic          in_bit    = 1'b0;
    logic          deb_en    = 1'b0;
    logic          deb3      = 1'b0;
    logic          mux_en    = 1'b0;
    logic          fclr      = 1'b0;
    logic          short     = 1'b0;
    logic [AW-1:0] wr_addr   = 8'h07;
    logic          wr_bit    = 1'b0;
    logic [3:0]    chan      = 4'h0;
    logic [3:0]    ch;
    logic          wr_ready, in_valid, in_bit_s, fault, out, cfg_err, bfd_flt;
    logic [AW-1:0] in_addr;
    int            err_total = 0;
    int            compares  = 0;
    always #50 clock_i = ~clock_i;
    sbo_if bus_if ();
    assign bus_if.bfd_short = short;
    sbo_source #(.DIV(8), .FRAME_LEN(8), .MODE(MODE_PEER), .N_CH(2)) sbo_source_i (
        .clock_i, .sys_rst_i, .bus(bus_if.source), .wr_valid_i(wr_valid),
        .wr_ready_o(wr_ready), .wr_addr_i(wr_addr), .wr_bit_i(wr_bit),
        .in_valid_o(in_valid), .in_addr_o(in_addr), .in_bit_o(in_bit_s),
        .channel_o(ch), .fault_o(fault), .fault_clr_i(fclr));
    sbo_device #(.FRAME_LEN(8), .OUT_ADDR(5), .IN_ADDR(5), .SYNC_DET_CYC(40)) sbo_device_i (
        .clock_i, .sys_rst_i, .bus(bus_if.device), .in_bit_i(in_bit),
        .cfg_deb_en_i(deb_en), .cfg_deb_three_i(deb3), .cfg_mux_en_i(mux_en),
        .cfg_chan_i(chan), .out_o(out), .cfg_error_o(cfg_err), .bfd_fault_o(bfd_flt));
    sbo_props sbo_props_i (.clock_i, .sys_rst_i, .bus_clk(bus_if.bus_clk),
        .src_data_oe(bus_if.src_data_oe), .dev_data_oe(bus_if.dev_data_oe),
        .src_bfd(bus_if.src_bfd));
    task automatic chk(input string n, input logic s, input logic e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("Error %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Source reports each sampled pulse; pulse 4 comes after the commit
    task automatic wait_pt(input logic [AW-1:0] a);
        int n;
        n = 0;
        @(posedge clock_i);
        while (!(in_valid === 1'b1 && in_addr === a))
        begin
            n++;
            if (n > 1000)
            begin
                err_total++;
                tally_and_finish;
            end
            @(posedge clock_i);
        end
    endtask
    task automatic frames(input int n);
        repeat (n) wait_pt(8'h04);
    endtask
    task automatic t_fifo;
        logic c0;
        wait_pt(8'h01);
        c0 = ch[0];
        wr_valid <= 1'b1;
        repeat (16) @(posedge clock_i);
        #1 chk("wr_ready full", wr_ready, 1'b0);
        @(posedge clock_i);
        wr_valid <= 1'b0;
        wait_pt(8'h01);
        chk("wr_ready drained", wr_ready, 1'b1);
        chk("channel step", ch[0], ~c0);
        chk("channel high", |ch[3:1], 1'b0);
    endtask
    task automatic t_commit;
        in_bit <= 1'b1;
        frames(1);
        wait_pt(8'h05);
        chk("wire bit", in_bit_s, 1'b1);
        chk("held", out, 1'b0);
        frames(1);
        chk("commit", out, 1'b1);
    endtask
    task automatic t_deb;
        for (int n = 3; n >= 2; n--)
        begin
            deb_en <= 1'b1;
            deb3 <= (n == 3);
            in_bit <= ~in_bit;
            for (int j = 1; j <= n + 1; j++)
            begin
                frames(1);
                chk("debounce", out, (j > n) ? in_bit : ~in_bit);
            end
        end
    endtask
    task automatic t_rej_fault;
        mux_en <= 1'b1;
        in_bit <= 1'b0;
        repeat (2) @(posedge clock_i);
        chk("cfg error", cfg_err, 1'b1);
        frames(3);
        chk("rejected", out, 1'b1);
        mux_en <= 1'b0;
        deb_en <= 1'b0;
        frames(3);
        chk("resumed", out, 1'b0);
        short <= 1'b1;
        in_bit <= 1'b1;
        frames(2);
        chk("no fault pulse", out, 1'b0);
        chk("source fault", fault, 1'b1);
        chk("device fault", bfd_flt, 1'b1);
        short <= 1'b0;
        fclr <= 1'b1;
        @(posedge clock_i);
        fclr <= 1'b0;
        frames(1);
        chk("fault cleared", fault, 1'b0);
        chk("after recovery", out, 1'b1);
    endtask
    initial
    begin
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_fifo;
        frames(2);
        t_commit;
        t_deb;
        t_rej_fault;
        tally_and_finish;
    end
endmodule // serial_bus_output_update_tb
